/* hw/tocc_pkg.sv */
package tocc_pkg;
    // Register byte addresses
    localparam logic [7:0] TOCC_ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] TOCC_ADDR_MODE = 8'h04;
    localparam logic [7:0] TOCC_ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] TOCC_ADDR_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] TOCC_ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] TOCC_ADDR_PRESCALE_STATE = 8'h14;
    // Status and control field positions
    localparam int TOCC_BIT_OVF = 7;
    localparam int TOCC_BIT_OVF_IE = 6;
    localparam int TOCC_BIT_CENTER = 5;
    localparam int TOCC_BIT_CLOCK_SOURCE_SELECT_HI = 4;
    localparam int TOCC_BIT_CLOCK_SOURCE_SELECT_LO = 3;
    localparam int TOCC_BIT_PS_HI = 2;
    localparam int TOCC_BIT_PS_LO = 0;
    // Mode register field positions
    localparam int TOCC_BIT_FEATURE_EN = 0;
    localparam int TOCC_BIT_WP_DISABLE = 2;
    // Reset values
    localparam logic [7:0] TOCC_RESET_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] TOCC_RESET_MODE = 8'h04;
    localparam logic [1:0] TOCC_RESET_IRQ = 2'h0;
    // Interrupt event bits
    localparam int TOCC_IRQ_OVERFLOW = 0;
    localparam int TOCC_IRQ_LOST_CLEAR = 1;
    // AXI responses
    localparam logic [1:0] TOCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TOCC_RESP_SLVERR = 2'h2;
    // Clock source encodings
    typedef enum logic [1:0] {
        TOCC_CLK_NONE = 2'b00,
        TOCC_CLK_SYSTEM = 2'b01,
        TOCC_CLK_FIXED = 2'b10,
        TOCC_CLK_UNDEF = 2'b11
    } tocc_clk_src_t;
endpackage : tocc_pkg

/* hw/tocc_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module tocc_prescaler
    import tocc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic src_tick,
    input wire logic [2:0] factor,
    // Output
    output logic count_enable,
    output logic [6:0] count_state
);
    logic [6:0] cnt;
    logic [6:0] mask;
    wire logic terminal;

    // Mask follows the live field, so a new factor applies on the next cycle
    assign mask = 7'((8'h01 << factor) - 8'h01); // RULE12 RULE13
    assign terminal = ((cnt & mask) == mask);
    assign count_state = cnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 7'h00;
            count_enable <= 1'b0;
        end else begin
            count_enable <= src_tick && terminal; // RULE12
            if (src_tick) begin
                cnt <= terminal ? 7'h00 : cnt + 7'h01;
            end
        end
    end
endmodule : tocc_prescaler
`default_nettype wire

/* hw/tocc_timer_ctrl.sv */
// Contract
// RULE1: Overflow event sets the overflow flag
// RULE2: Clear needs read while set, then write 0
// RULE3: Writing 1 to flag changes nothing
// RULE4: Overflow between read and write voids clear
// RULE5: Interrupt while flag set and enable set
// RULE6: Center select picks up-down counting
// RULE7: Protected fields writable only with disable bit
// RULE8: Source 00 stops the counter
// RULE9: Second instance: 01 halves unless feature set
// RULE10: First instance: 01 is full system clock
// RULE11: Source 10 picks fixed frequency clock
// RULE12: Prescaler divides by two to field
// RULE13: New prescale acts next cycle
// RULE14: Control write restarts counter read latch
// RULE15: Source 11 behaves like no clock
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tocc_timer_ctrl
    import tocc_pkg::*;
#(
    parameter bit SECOND_INSTANCE = 1'b1
)(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Counter side, same clock domain
    input wire logic OVERFLOW_EVENT,
    input wire logic FIXED_CLK_TICK,
    output logic COUNT_ENABLE,
    output logic COUNT_UP_DOWN,
    output logic READ_LATCH_RESTART,
    // Interrupt
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic overflow_flag;
    logic overflow_irq_enable;
    logic center_aligned_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale_factor;
    logic [7:0] mode_reg;
    logic clear_armed;
    logic clear_spoiled;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic half_toggle;
    logic [6:0] prescale_state;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data may arrive in either order

    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire logic aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire logic w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire logic have_aw = aw_held || aw_take;
    wire logic have_w = w_held || w_take;
    wire logic wr_fire = have_aw && have_w && !S_AXI_BVALID;
    wire logic [7:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
    wire logic [31:0] wr_data = w_held ? w_data : S_AXI_WDATA;
    wire logic [3:0] wr_strb = w_held ? w_strb : S_AXI_WSTRB;
    wire logic wr_lane0 = wr_fire && wr_strb[0];

    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;

    wire logic wr_sc = wr_lane0 && (wr_addr == TOCC_ADDR_STATUS_CONTROL);
    wire logic wr_mode = wr_lane0 && (wr_addr == TOCC_ADDR_MODE);
    wire logic wr_ien = wr_lane0 && (wr_addr == TOCC_ADDR_IRQ_ENABLE);
    wire logic wr_iclr = wr_lane0 && (wr_addr == TOCC_ADDR_IRQ_CLEAR);
    wire logic wr_mapped = (wr_addr == TOCC_ADDR_STATUS_CONTROL) || (wr_addr == TOCC_ADDR_MODE)
        || (wr_addr == TOCC_ADDR_IRQ_STATUS) || (wr_addr == TOCC_ADDR_IRQ_ENABLE)
        || (wr_addr == TOCC_ADDR_IRQ_CLEAR) || (wr_addr == TOCC_ADDR_PRESCALE_STATE);

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end
    end

    // Data may come first; it waits here until its address arrives
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            S_AXI_BVALID <= 1'b0;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Unmapped offsets still complete, so a stray write cannot hang the bus
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            S_AXI_BRESP <= TOCC_RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BRESP <= wr_mapped ? TOCC_RESP_OKAY : TOCC_RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    wire logic rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    wire logic rd_sc = rd_fire && (S_AXI_ARADDR == TOCC_ADDR_STATUS_CONTROL);
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    wire logic [7:0] sc_value = {overflow_flag, overflow_irq_enable, center_aligned_select,
        clock_source_select, prescale_factor};
    logic [31:0] rd_mux;
    logic rd_ok;

    always_comb begin
        rd_ok = 1'b1;
        unique case (S_AXI_ARADDR)
            TOCC_ADDR_STATUS_CONTROL: rd_mux = {24'h000000, sc_value};
            TOCC_ADDR_MODE: rd_mux = {24'h000000, mode_reg};
            TOCC_ADDR_IRQ_STATUS: rd_mux = {30'h00000000, irq_status};
            TOCC_ADDR_IRQ_ENABLE: rd_mux = {30'h00000000, irq_enable};
            TOCC_ADDR_PRESCALE_STATE: rd_mux = {25'h0000000, prescale_state};
            TOCC_ADDR_IRQ_CLEAR: rd_mux = 32'h0000_0000;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            S_AXI_RVALID <= 1'b0;
        end else if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Data is captured with the address, so a later register change cannot tear it
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= TOCC_RESP_OKAY;
        end else if (rd_fire) begin
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= rd_ok ? TOCC_RESP_OKAY : TOCC_RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overflow flag and its clearing sequence

    wire logic wp_disable = mode_reg[TOCC_BIT_WP_DISABLE];
    wire logic feature_en = mode_reg[TOCC_BIT_FEATURE_EN];
    wire logic clear_req = wr_sc && !wr_data[TOCC_BIT_OVF]; // RULE3
    wire logic arm_read = rd_sc && overflow_flag;
    // An overflow after the arming read, or in the write cycle itself, spoils the clear
    wire logic clear_late = clear_spoiled || OVERFLOW_EVENT;
    wire logic clear_ok = clear_req && clear_armed && !clear_late; // RULE2 RULE4
    wire logic clear_void = clear_req && clear_armed && clear_late; // RULE4

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            overflow_flag <= TOCC_RESET_STATUS_CONTROL[TOCC_BIT_OVF];
        end else if (OVERFLOW_EVENT) begin
            overflow_flag <= 1'b1; // RULE1
        end else if (clear_ok) begin
            overflow_flag <= 1'b0; // RULE2
        end
    end

    // Any control write ends the sequence, so a stale read cannot clear a later flag
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            clear_armed <= 1'b0;
        end else if (wr_sc) begin
            clear_armed <= 1'b0; // RULE2
        end else if (arm_read) begin
            clear_armed <= 1'b1; // RULE2
        end
    end

    // Remembers an overflow that lands after the arming read
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            clear_spoiled <= 1'b0;
        end else if (wr_sc) begin
            clear_spoiled <= 1'b0;
        end else if (arm_read) begin
            clear_spoiled <= OVERFLOW_EVENT; // RULE4
        end else if (OVERFLOW_EVENT) begin
            clear_spoiled <= 1'b1; // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            overflow_irq_enable <= TOCC_RESET_STATUS_CONTROL[TOCC_BIT_OVF_IE];
        end else if (wr_sc) begin
            overflow_irq_enable <= wr_data[TOCC_BIT_OVF_IE]; // RULE5
        end
    end

    // Protected fields ignore writes unless the mode disable bit is set, the open interrupt enable beside them does not
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            center_aligned_select <= TOCC_RESET_STATUS_CONTROL[TOCC_BIT_CENTER];
            clock_source_select <= TOCC_RESET_STATUS_CONTROL[TOCC_BIT_CLOCK_SOURCE_SELECT_HI:TOCC_BIT_CLOCK_SOURCE_SELECT_LO];
            prescale_factor <= TOCC_RESET_STATUS_CONTROL[TOCC_BIT_PS_HI:TOCC_BIT_PS_LO];
        end else if (wr_sc && wp_disable) begin
            center_aligned_select <= wr_data[TOCC_BIT_CENTER]; // RULE7
            clock_source_select <= wr_data[TOCC_BIT_CLOCK_SOURCE_SELECT_HI:TOCC_BIT_CLOCK_SOURCE_SELECT_LO]; // RULE7
            prescale_factor <= wr_data[TOCC_BIT_PS_HI:TOCC_BIT_PS_LO]; // RULE7
        end
    end

    // The mode register itself is never protected
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            mode_reg <= TOCC_RESET_MODE;
        end else if (wr_mode) begin
            mode_reg <= wr_data[7:0];
        end
    end

    assign COUNT_UP_DOWN = center_aligned_select; // RULE6
    assign READ_LATCH_RESTART = wr_sc; // RULE14

    ////////////////////////////////////////////////////////////////////////
    // Clock source selection

    logic src_tick;
    wire logic sys_tick = (SECOND_INSTANCE && !feature_en) ? half_toggle : 1'b1; // RULE9 RULE10

    always_comb begin
        unique case (tocc_clk_src_t'(clock_source_select))
            TOCC_CLK_NONE: src_tick = 1'b0; // RULE8
            TOCC_CLK_SYSTEM: src_tick = sys_tick; // RULE9 RULE10
            TOCC_CLK_FIXED: src_tick = FIXED_CLK_TICK; // RULE11
            TOCC_CLK_UNDEF: src_tick = 1'b0; // RULE15
        endcase
    end

    // Free running, so the halved clock keeps its phase across source changes
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            half_toggle <= 1'b0;
        end else begin
            half_toggle <= !half_toggle;
        end
    end

    // Registered enable adds one cycle of latency but keeps the counter glitch free
    tocc_prescaler u_prescaler (
        .clk(SYS_CLK),
        .rst(RESET),
        .src_tick(src_tick),
        .factor(prescale_factor),
        .count_enable(COUNT_ENABLE),
        .count_state(prescale_state)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear

    wire logic [1:0] irq_events = {clear_void, OVERFLOW_EVENT};
    wire logic [1:0] irq_clear = wr_iclr ? wr_data[1:0] : 2'b00;

    // One sticky bit per event; a set wins over a clear in the same cycle
    for (genvar b = 0; b < 2; b++) begin : g_irq_bit
        always_ff @(posedge SYS_CLK or posedge RESET) begin
            if (RESET) begin
                irq_status[b] <= TOCC_RESET_IRQ[b];
            end else if (irq_events[b]) begin
                irq_status[b] <= 1'b1;
            end else if (irq_clear[b]) begin
                irq_status[b] <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            irq_enable <= TOCC_RESET_IRQ;
        end else if (wr_ien) begin
            irq_enable <= wr_data[1:0];
        end
    end

    // Overflow request follows the flag level itself
    assign IRQ = (overflow_irq_enable && overflow_flag) || |(irq_status & irq_enable); // RULE5

endmodule : tocc_timer_ctrl
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import tocc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0, ovf_evt = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, last_resp;
    logic awready, wready, bvalid, arready, rvalid, ce, updown, restart, irq, ce_first;
    logic [31:0] seed = 32'hf83bcb8f;
    int num_errors = 0, num_checks = 0, restarts = 0;

    tocc_timer_ctrl dut_u (
        .SYS_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .OVERFLOW_EVENT(ovf_evt), .FIXED_CLK_TICK(tick),
        .COUNT_ENABLE(ce), .COUNT_UP_DOWN(updown), .READ_LATCH_RESTART(restart), .IRQ(irq)
    );

    // First-instance flavour shares the bus; only its count enable is watched
    tocc_timer_ctrl #(.SECOND_INSTANCE(1'b0)) dut_first_u (
        .SYS_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
        .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(),
        .S_AXI_RVALID(), .S_AXI_RREADY(rready), .OVERFLOW_EVENT(ovf_evt), .FIXED_CLK_TICK(tick),
        .COUNT_ENABLE(ce_first), .COUNT_UP_DOWN(), .READ_LATCH_RESTART(), .IRQ()
    );

    always #20 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    always @(negedge clk) if (restart === 1'b1) restarts++;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int exp_ce(input logic [1:0] src, input logic [2:0] ps, input logic feat);
        int base;
        base = (src == TOCC_CLK_SYSTEM) ? (feat ? 512 : 256) : (src == TOCC_CLK_FIXED) ? 256 : 0;
        return base >> ps;
    endfunction : exp_ce

    function automatic logic near(input int n, input int e);
        return (e == 0) ? (n == 0) : (n >= e - 1 && n <= e + 1);
    endfunction : near

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // Readies are looked at mid-cycle, where the combinational ones have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(da && dw)) begin
            @(negedge clk);
            ta = !da && awready === 1'b1;
            tw = !dw && wready === 1'b1;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da = da | ta;
            dw = dw | tw;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        // Ready comes late on purpose so the response has to wait
        @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
        last_resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        d = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask : rc

    task automatic ovf;
        ovf_evt <= 1'b1;
        @(posedge clk);
        ovf_evt <= 1'b0;
    endtask : ovf

    task automatic irq_is(input logic e);
        @(negedge clk);
        chk("irq", e, irq);
        @(posedge clk);
    endtask : irq_is

    task automatic cnt(output int n, output int m);
        n = 0;
        m = 0;
        repeat (512) begin
            @(negedge clk);
            if (ce === 1'b1) n++;
            if (ce_first === 1'b1) m++;
        end
        @(posedge clk);
    endtask : cnt

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        int n;
        int e;
        int m;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc("sc", TOCC_ADDR_STATUS_CONTROL, 32'h0);
        rc("mode", TOCC_ADDR_MODE, 32'h4);
        rc("bad", 8'h18, 32'h0);
        chk("resp", TOCC_RESP_SLVERR, last_resp);
        wr(8'h18, 8'h00);
        chk("bresp", TOCC_RESP_SLVERR, last_resp);
        wr(TOCC_ADDR_MODE, 8'h00);
        chk("bresp_ok", TOCC_RESP_OKAY, last_resp);
        wr(TOCC_ADDR_STATUS_CONTROL, 8'h7f);
        rc("sc_prot", TOCC_ADDR_STATUS_CONTROL, 32'h40);
        wr(TOCC_ADDR_MODE, 8'h04);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            n = restarts;
            wr(TOCC_ADDR_STATUS_CONTROL, {1'b0, seed[6:0]});
            wr(TOCC_ADDR_IRQ_ENABLE, 8'h00);
            chk("restart", n + 1, restarts);
            rc("sc", TOCC_ADDR_STATUS_CONTROL, {25'h0, seed[6:0]});
            @(negedge clk);
            chk("updown", seed[5], updown);
            @(posedge clk);
        end
        wr(TOCC_ADDR_STATUS_CONTROL, 8'h40);
        ovf();
        irq_is(1'b1);
        wr(TOCC_ADDR_STATUS_CONTROL, 8'h40);
        rc("no_read", TOCC_ADDR_STATUS_CONTROL, 32'hc0);
        wr(TOCC_ADDR_STATUS_CONTROL, 8'hc0);
        rc("one", TOCC_ADDR_STATUS_CONTROL, 32'hc0);
        wr(TOCC_ADDR_STATUS_CONTROL, 8'h40);
        rc("clear", TOCC_ADDR_STATUS_CONTROL, 32'h40);
        irq_is(1'b0);
        ovf();
        rd(TOCC_ADDR_STATUS_CONTROL, v);
        ovf();
        wr(TOCC_ADDR_STATUS_CONTROL, 8'h40);
        rc("void", TOCC_ADDR_STATUS_CONTROL, 32'hc0);
        rc("ist", TOCC_ADDR_IRQ_STATUS, 32'h3);
        wr(TOCC_ADDR_STATUS_CONTROL, 8'h00);
        ovf();
        irq_is(1'b0);
        rc("flag", TOCC_ADDR_STATUS_CONTROL, 32'h80);
        wr(TOCC_ADDR_IRQ_ENABLE, 8'h03);
        irq_is(1'b1);
        wr(TOCC_ADDR_IRQ_CLEAR, 8'h03);
        rc("ist", TOCC_ADDR_IRQ_STATUS, 32'h0);
        rc("iclr", TOCC_ADDR_IRQ_CLEAR, 32'h0);
        irq_is(1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(TOCC_ADDR_MODE, {7'h02, i[2]});
            wr(TOCC_ADDR_STATUS_CONTROL, {3'b000, i[1:0], seed[2:0]});
            cnt(n, m);
            e = exp_ce(i[1:0], seed[2:0], i[2]);
            chk("ce", 32'h1, near(n, e));
            chk("ce_first", 32'h1, near(m, exp_ce(i[1:0], seed[2:0], 1'b1)));
        end
        conclude();
    end

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule : tb
`default_nettype wire

/* test/tocc_timer_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tocc_timer_ctrl_chk
    import tocc_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Register bus
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Counter side and interrupt
    input wire logic OVERFLOW_EVENT,
    input wire logic COUNT_UP_DOWN,
    input wire logic READ_LATCH_RESTART,
    input wire logic IRQ
);
    wire wr_hs = (S_AXI_AWVALID && S_AXI_AWREADY) || (S_AXI_WVALID && S_AXI_WREADY);
    wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while data pending");
    a_read_answer: assert property (ar_hs |=> S_AXI_RVALID)
        else $error("read data late");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held");
    a_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response not held");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
        else $error("write response late");
    a_latch_restart: assert property (READ_LATCH_RESTART |=> S_AXI_BVALID && S_AXI_BRESP == TOCC_RESP_OKAY)
        else $error("latch restart without control write");
    a_irq_rise: assert property ($rose(IRQ) |-> $past(OVERFLOW_EVENT || wr_hs))
        else $error("interrupt rose without cause");
    a_irq_fall: assert property ($fell(IRQ) |-> $past(wr_hs))
        else $error("interrupt fell without a write");
    a_mode_stable: assert property ($changed(COUNT_UP_DOWN) |-> $past(wr_hs) || $past(wr_hs, 2))
        else $error("count mode changed without a write");
endmodule : tocc_timer_ctrl_chk
////////////////////////////////////////////////////////////////
bind tocc_timer_ctrl tocc_timer_ctrl_chk chk_u (
    .SYS_CLK, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .OVERFLOW_EVENT, .COUNT_UP_DOWN,
    .READ_LATCH_RESTART, .IRQ
);
`default_nettype wire
